// ==== design/rgc_pkg.sv ====
/*
 * Package for the reciprocal gate counter: register offsets, field
 * positions, reset values, widths and arming encodings.
 * Assumes a plain synchronous register port on a single 25 MHz clock.
 */
package rgc_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_W  = 4;
    localparam int DATA_W  = 32;
    localparam int CHAIN_W = 32;
    localparam int INTERP_W = 16;

    // ************************************************************
    // Register offsets (word indices on the register port)
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CMD     = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ST  = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_SIG_CNT = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_REF_CNT = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_STA_CNT = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_STP_CNT = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CAL_LEN = 4'h9;

    // ************************************************************
    // CTRL fields
    // ************************************************************
    localparam int CTRL_SRC_LSB  = 0;   // 3 bits: 0 ext, 1..7 trig line
    localparam int CTRL_MODE_LSB = 3;   // 2 bits arming mode
    localparam int CTRL_ROUTE    = 5;   // 1 = shared input
    localparam int CTRL_FE_LSB   = 8;   // 8 bits front-end config
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // CMD bits (write one to act)
    localparam int CMD_ARM_START = 0;
    localparam int CMD_ARM_STOP  = 1;
    localparam int CMD_CAL_START = 2;
    localparam int CMD_CAL_STOP  = 3;

    // IRQ bits
    localparam int IRQ_W       = 4;
    localparam int IRQ_OPEN    = 0;
    localparam int IRQ_DONE    = 1;
    localparam int IRQ_CAL     = 2;
    localparam int IRQ_ARMEVT  = 3;

    // Arming modes
    localparam logic [1:0] MODE_IMMED = 2'h0;  // host command alone
    localparam logic [1:0] MODE_START = 2'h1;  // arm edge gates start
    localparam logic [1:0] MODE_STOP  = 2'h2;  // arm edge gates stop
    localparam logic [1:0] MODE_BOTH  = 2'h3;

    localparam logic [7:0] CAL_LEN_RST = 8'h04;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ARMED, ST_OPEN, ST_CLOSING, ST_DRAIN
    } rgc_state_t;

endpackage : rgc_pkg

// ==== design/rgc_edge.sv ====
/*
 * Rising edge detector with one-flop history on a synchronous input.
 * Assumes the input is already synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module rgc_edge
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Level in, pulse out
    input  wire logic level_in,
    output logic      rise
);
    logic prev_q;

    // History flop for the edge compare
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) prev_q <= 1'b0;
        else        prev_q <= level_in;
    end

    assign rise = level_in & ~prev_q;
endmodule // rgc_edge
`default_nettype wire

// ==== design/rgc_interp.sv ====
/*
 * One interpolation channel: times the width of the error pulse, then
 * counts reference ticks during a slow discharge of that width.
 * Assumes a reference tick pulse synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module rgc_interp
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // Control
    input  wire logic                          clear,
    input  wire logic                          err_pulse,
    input  wire logic                          ref_tick,
    // Result
    output logic [rgc_pkg::INTERP_W-1:0]       count,
    output logic                               busy
);
    logic [rgc_pkg::INTERP_W-1:0] charge_q;
    logic [rgc_pkg::INTERP_W-1:0] count_q;
    logic                         charging_q;
    logic                         drain_q;
    logic                         drain_end;

    // Charge grows with the pulse; drain eats one unit per reference tick
    assign drain_end = drain_q & ref_tick
                     & (charge_q == rgc_pkg::INTERP_W'(1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            charge_q   <= '0;
            count_q    <= '0;
            charging_q <= 1'b0;
            drain_q    <= 1'b0;
        end
        else if (clear)
        begin
            charge_q   <= '0;
            count_q    <= '0;
            charging_q <= 1'b0;
            drain_q    <= 1'b0;
        end
        else
        begin
            charging_q <= err_pulse;
            if (err_pulse)
                charge_q <= charge_q + rgc_pkg::INTERP_W'(1);
            if (charging_q && !err_pulse && charge_q != '0)
                drain_q <= 1'b1;
            if (drain_q && ref_tick)
            begin
                count_q  <= count_q + rgc_pkg::INTERP_W'(1);
                charge_q <= charge_q - rgc_pkg::INTERP_W'(1);
            end
            if (drain_end)
                drain_q <= 1'b0;
        end
    end

    assign count = count_q;
    assign busy  = err_pulse | charging_q | drain_q;
endmodule // rgc_interp
`default_nettype wire

// ==== design/rgc_top.sv ====
/*
 * Reciprocal gate counter measurement block. Holds the register file,
 * arming logic, gate control, input/reference chains, two interpolation
 * channels with calibration pulses, and the interrupt logic.
 * Assumes all inputs (signal, reference, arming) synchronous to clk and
 * a host on a plain strobe register port.
 */
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rgc_top
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // Register port
    input  wire logic [rgc_pkg::ADDR_W-1:0]    addr,
    input  wire logic [rgc_pkg::DATA_W-1:0]    wdata,
    input  wire logic                          wr_stb,
    input  wire logic                          rd_stb,
    output logic      [rgc_pkg::DATA_W-1:0]    rdata,
    // Measured inputs and reference
    input  wire logic                          sig_in1,
    input  wire logic                          sig_in2,
    input  wire logic                          ref_in,
    // Arming sources
    input  wire logic                          arm_ext,
    input  wire logic [6:0]                    arm_trig,
    // Front end
    output logic      [7:0]                    fe_cfg,
    output logic                               route_shared,
    output logic                               chan1_sig,
    output logic                               chan2_sig,
    output logic                               gate_open,
    // Interrupt
    output logic                               irq
);
    // ************************************************************
    // Registers and wires
    // ************************************************************
    rgc_pkg::rgc_state_t state_q, state_d;
    logic [15:0]                   ctrl_q;
    logic [rgc_pkg::IRQ_W-1:0]     irq_st_q;
    logic [rgc_pkg::IRQ_W-1:0]     irq_msk_q;
    logic [rgc_pkg::CHAIN_W-1:0]   sig_cnt_q;
    logic [rgc_pkg::CHAIN_W-1:0]   ref_cnt_q;
    logic [7:0]                    cal_len_q;
    logic [7:0]                    cal_cnt_q;
    logic                          cal_sta_q;
    logic                          cal_stp_q;
    logic                          stop_armed_q;
    logic                          pend_start_q;
    logic                          sta_err_q;
    logic                          stp_err_q;
    logic [rgc_pkg::DATA_W-1:0]    rdata_q;

    logic        wr_ctrl, wr_cmd, wr_irq, wr_msk, wr_cal;
    logic        arm_start, arm_stop, cal_start, cal_stop;
    logic        sig_edge, ref_tick, arm_lvl, arm_edge;
    logic        mode_start_gated, mode_stop_gated;
    logic        open_now, close_now;
    logic        sta_busy, stp_busy;
    logic        sta_pulse, stp_pulse;
    logic [rgc_pkg::INTERP_W-1:0] sta_cnt, stp_cnt;
    logic [rgc_pkg::IRQ_W-1:0]    irq_set;
    logic [2:0]  arm_src;
    logic [1:0]  arm_mode;
    logic [7:0]  trig_sel;
    logic        chan1_raw;

    // ************************************************************
    // Edge detection
    // ************************************************************
    rgc_edge u_sig_edge
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .level_in (chan1_raw),
        .rise     (sig_edge)
    );

    rgc_edge u_ref_edge
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .level_in (ref_in),
        .rise     (ref_tick)
    );

    rgc_edge u_arm_edge
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .level_in (arm_lvl),
        .rise     (arm_edge)
    );

    // ************************************************************
    // Register decode
    // ************************************************************
    assign wr_ctrl   = wr_stb & (addr == rgc_pkg::OFS_CTRL);
    assign wr_cmd    = wr_stb & (addr == rgc_pkg::OFS_CMD);
    assign wr_irq    = wr_stb & (addr == rgc_pkg::OFS_IRQ_ST);
    assign wr_msk    = wr_stb & (addr == rgc_pkg::OFS_IRQ_MSK);
    assign wr_cal    = wr_stb & (addr == rgc_pkg::OFS_CAL_LEN);
    assign arm_start = wr_cmd & wdata[rgc_pkg::CMD_ARM_START];
    assign arm_stop  = wr_cmd & wdata[rgc_pkg::CMD_ARM_STOP];
    assign cal_start = wr_cmd & wdata[rgc_pkg::CMD_CAL_START];
    assign cal_stop  = wr_cmd & wdata[rgc_pkg::CMD_CAL_STOP];

    // ************************************************************
    // Configuration, routing and arming source
    // ************************************************************
    assign fe_cfg       = ctrl_q[rgc_pkg::CTRL_FE_LSB +: 8];
    assign route_shared = ctrl_q[rgc_pkg::CTRL_ROUTE];
    assign arm_src      = ctrl_q[rgc_pkg::CTRL_SRC_LSB +: 3];
    assign arm_mode     = ctrl_q[rgc_pkg::CTRL_MODE_LSB +: 2];
    // Source 0 is the external input, 1..7 the trigger lines
    assign trig_sel     = {arm_trig, arm_ext};
    assign arm_lvl      = trig_sel[arm_src];
    // Shared mode feeds input one to both channels
    assign chan1_raw    = sig_in1;
    assign chan1_sig    = sig_in1;
    assign chan2_sig    = route_shared ? sig_in1 : sig_in2;

    // Modes decide whether an arming edge is needed at start or stop
    assign mode_start_gated = (arm_mode == rgc_pkg::MODE_START)
                            | (arm_mode == rgc_pkg::MODE_BOTH);
    assign mode_stop_gated  = (arm_mode == rgc_pkg::MODE_STOP)
                            | (arm_mode == rgc_pkg::MODE_BOTH);

    // ************************************************************
    // Gate control, synchronous to the measured input
    // ************************************************************
    assign open_now  = (state_q == rgc_pkg::ST_ARMED) & sig_edge;
    assign close_now = (state_q == rgc_pkg::ST_CLOSING) & sig_edge;

    // Waiting states hold until the host or an input edge moves them, ST_DRAIN until both interpolators are idle
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            rgc_pkg::ST_IDLE:
                if (arm_start && !mode_start_gated)
                    state_d = rgc_pkg::ST_ARMED;
                else if (arm_start)
                    state_d = rgc_pkg::ST_IDLE;
            rgc_pkg::ST_ARMED:
                if (open_now)
                    state_d = rgc_pkg::ST_OPEN;
            rgc_pkg::ST_OPEN:
                if (stop_armed_q && (!mode_stop_gated || arm_edge))
                    state_d = rgc_pkg::ST_CLOSING;
            rgc_pkg::ST_CLOSING:
                if (close_now)
                    state_d = rgc_pkg::ST_DRAIN;
            rgc_pkg::ST_DRAIN:
                if (!sta_busy && !stp_busy)
                    state_d = rgc_pkg::ST_IDLE;
        endcase
        // Gated start: wait for arming edge after the host arm
        if (state_q == rgc_pkg::ST_IDLE && pend_start_q && arm_edge)
            state_d = rgc_pkg::ST_ARMED;
        // A fresh arm always restarts the sequence
        if (arm_start && state_q != rgc_pkg::ST_IDLE)
            state_d = mode_start_gated ? rgc_pkg::ST_IDLE
                                       : rgc_pkg::ST_ARMED;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q      <= rgc_pkg::ST_IDLE;
            pend_start_q <= 1'b0;
            stop_armed_q <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            pend_start_q <= arm_start ? mode_start_gated
                          : (arm_edge ? 1'b0 : pend_start_q);
            stop_armed_q <= arm_start ? 1'b0
                          : (arm_stop ? 1'b1 : stop_armed_q);
        end
    end

    assign gate_open = (state_q == rgc_pkg::ST_OPEN)
                     | (state_q == rgc_pkg::ST_CLOSING);

    // ************************************************************
    // Input and reference chains
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sig_cnt_q <= '0;
            ref_cnt_q <= '0;
        end
        else if (arm_start)
        begin
            sig_cnt_q <= '0;
            ref_cnt_q <= '0;
        end
        else
        begin
            // Both count over the same gate window
            if ((gate_open && !close_now && sig_edge) || open_now)
                sig_cnt_q <= sig_cnt_q + 1'b1;
            if (((gate_open && !close_now) || open_now) && ref_tick)
                ref_cnt_q <= ref_cnt_q + 1'b1;
        end
    end

    // ************************************************************
    // Error pulses: input edge to next reference tick, or calibration
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sta_err_q <= 1'b0;
            stp_err_q <= 1'b0;
            cal_cnt_q <= '0;
            cal_sta_q <= 1'b0;
            cal_stp_q <= 1'b0;
        end
        else
        begin
            if (open_now)
                sta_err_q <= 1'b1;
            else if (ref_tick)
                sta_err_q <= 1'b0;
            if (close_now)
                stp_err_q <= 1'b1;
            else if (ref_tick)
                stp_err_q <= 1'b0;
            // Calibration pulse lasts cal_len reference ticks
            if (cal_start || cal_stop)
            begin
                cal_sta_q <= cal_start;
                cal_stp_q <= cal_stop;
                cal_cnt_q <= cal_len_q;
            end
            else if ((cal_sta_q || cal_stp_q) && ref_tick)
            begin
                cal_cnt_q <= cal_cnt_q - 8'h01;
                if (cal_cnt_q == 8'h01)
                begin
                    cal_sta_q <= 1'b0;
                    cal_stp_q <= 1'b0;
                end
            end
        end
    end

    assign sta_pulse = sta_err_q | cal_sta_q;
    assign stp_pulse = stp_err_q | cal_stp_q;

    // ************************************************************
    // Interpolation channels
    // ************************************************************
    rgc_interp u_sta
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .clear     (arm_start | cal_start),
        .err_pulse (sta_pulse),
        .ref_tick  (ref_tick),
        .count     (sta_cnt),
        .busy      (sta_busy)
    );

    rgc_interp u_stp
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .clear     (arm_start | cal_stop),
        .err_pulse (stp_pulse),
        .ref_tick  (ref_tick),
        .count     (stp_cnt),
        .busy      (stp_busy)
    );

    // ************************************************************
    // Control registers and interrupt
    // ************************************************************
    logic cal_busy_q;

    assign irq_set[rgc_pkg::IRQ_OPEN]   = open_now;
    assign irq_set[rgc_pkg::IRQ_DONE]   = (state_q == rgc_pkg::ST_DRAIN)
                                        & !sta_busy & !stp_busy;
    assign irq_set[rgc_pkg::IRQ_CAL]    = cal_busy_q & !sta_busy
                                        & !stp_busy & !cal_sta_q
                                        & !cal_stp_q;
    assign irq_set[rgc_pkg::IRQ_ARMEVT] = arm_edge;

    // Set beats a write-one clear in the same cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q     <= rgc_pkg::CTRL_RST;
            irq_st_q   <= '0;
            irq_msk_q  <= '0;
            cal_len_q  <= rgc_pkg::CAL_LEN_RST;
            cal_busy_q <= 1'b0;
        end
        else
        begin
            if (wr_ctrl) ctrl_q    <= wdata[15:0];
            if (wr_msk)  irq_msk_q <= wdata[rgc_pkg::IRQ_W-1:0];
            if (wr_cal)  cal_len_q <= wdata[7:0];
            irq_st_q <= (irq_st_q & ~({rgc_pkg::IRQ_W{wr_irq}}
                        & wdata[rgc_pkg::IRQ_W-1:0])) | irq_set;
            cal_busy_q <= (cal_start | cal_stop) ? 1'b1
                        : (irq_set[rgc_pkg::IRQ_CAL] ? 1'b0 : cal_busy_q);
        end
    end

    assign irq = |(irq_st_q & irq_msk_q);

    // ************************************************************
    // Read data, one cycle after the strobe
    // ************************************************************
    logic [rgc_pkg::DATA_W-1:0] rd_mux;

    always_comb
    begin
        unique case (addr)
            rgc_pkg::OFS_CTRL:    rd_mux = {16'h0000, ctrl_q};
            rgc_pkg::OFS_STATUS:  rd_mux = {27'h0, stop_armed_q, sta_busy,
                                            stp_busy, gate_open,
                                            state_q == rgc_pkg::ST_ARMED};
            rgc_pkg::OFS_IRQ_ST:  rd_mux = {28'h0, irq_st_q};
            rgc_pkg::OFS_IRQ_MSK: rd_mux = {28'h0, irq_msk_q};
            rgc_pkg::OFS_SIG_CNT: rd_mux = sig_cnt_q;
            rgc_pkg::OFS_REF_CNT: rd_mux = ref_cnt_q;
            rgc_pkg::OFS_STA_CNT: rd_mux = {16'h0000, sta_cnt};
            rgc_pkg::OFS_STP_CNT: rd_mux = {16'h0000, stp_cnt};
            rgc_pkg::OFS_CAL_LEN: rd_mux = {24'h0, cal_len_q};
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)      rdata_q <= '0;
        else if (rd_stb) rdata_q <= rd_mux;
        else             rdata_q <= '0;
    end

    assign rdata = rdata_q;
endmodule // rgc_top
`default_nettype wire

// ==== verification/rgc_assertions.sv ====
/* Port checker for rgc_top.
   Assumes a bind onto rgc_top; one clock, async low reset. */
`timescale 1ns/1ps
`default_nettype none
module rgc_assertions
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Register port
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [31:0] rdata,
    // Signals and front end
    input wire logic        sig_in1,
    input wire logic        sig_in2,
    input wire logic [7:0]  fe_cfg,
    input wire logic        route_shared,
    input wire logic        chan1_sig,
    input wire logic        chan2_sig,
    input wire logic        gate_open,
    input wire logic        irq
);
    // ********************
    // Properties
    // ********************
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire       ctl_wr  = wr_stb && addr == rgc_pkg::OFS_CTRL;
    wire       cmd_wr  = wr_stb && addr == rgc_pkg::OFS_CMD;
    wire       msk_wr  = wr_stb && addr == rgc_pkg::OFS_IRQ_MSK;
    wire [7:0] w_fe    = wdata[15:8];
    wire       w_sh    = wdata[5];
    wire       ch2_exp = route_shared ? sig_in1 : sig_in2;
    // Gate edges trail a signal pulse by the edge-detect delay only
    sequence sig_late;
        $past(sig_in1) || $past(sig_in1, 2) || $past(sig_in1, 3);
    endsequence
    AST_RD_IDLE: assert property (!rd_stb |=> rdata == 32'h0)
        else $error("read data outside read cycle");
    AST_FE_CFG: assert property (ctl_wr |=> fe_cfg == $past(w_fe))
        else $error("fe_cfg not loaded");
    AST_ROUTE: assert property (ctl_wr |=> route_shared == $past(w_sh))
        else $error("route select not loaded");
    AST_CH1: assert property (chan1_sig == sig_in1)
        else $error("channel one wrong");
    AST_CH2: assert property (chan2_sig == ch2_exp)
        else $error("channel two wrong");
    AST_ARM_CLR: assert property (cmd_wr && wdata[0] |=> !gate_open)
        else $error("gate open after re-arm");
    AST_OPEN: assert property ($rose(gate_open) |-> sig_late)
        else $error("gate opened without signal edge");
    AST_CLOSE: assert property ($fell(gate_open) && !$past(wr_stb)
        && !$past(wr_stb, 2) |-> sig_late)
        else $error("gate closed without signal edge");
    AST_IRQ_MASK: assert property (msk_wr && wdata == 32'h0 |=> !irq)
        else $error("irq high with all masked");
    COV_OPEN: cover property ($rose(gate_open));
    COV_CLOSE: cover property ($fell(gate_open));
    COV_IRQ: cover property ($rose(irq));
endmodule // rgc_assertions
`default_nettype wire

// ==== verification/rgc_src.sv ====
/* Host-side source: reference ticks, measured signal, gate timer.
   Assumes the bench pulses tmr_go for one cycle to start a gate. */
`timescale 1ns/1ps
`default_nettype none
module rgc_src
#(
    parameter int REF_DIV  = 4,
    parameter int SIG_DIV  = 20,
    parameter int GATE_CYC = 200
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Host gate timer
    input  wire logic tmr_go,
    output logic      tmr_done,
    // One-cycle pulses
    output logic      ref_in,
    output logic      sig_in1
);
    int cnt_q;
    int tmr_q;
    // SIG_DIV a multiple of REF_DIV keeps the count ratio exact
    assign ref_in   = (cnt_q % REF_DIV) == 0;
    assign sig_in1  = (cnt_q % SIG_DIV) == 0;
    assign tmr_done = tmr_q == 0;
    // Gate length is the host's own count, not the block's
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 0;
            tmr_q <= 0;
        end
        else
        begin
            cnt_q <= cnt_q + 1;
            tmr_q <= tmr_go ? GATE_CYC : (tmr_q > 0 ? tmr_q - 1 : 0);
        end
    end
endmodule // rgc_src
`default_nettype wire

// ==== verification/rgc_top_tb_top.sv ====
/* Bench for rgc_top: bus tasks, scenario tasks, verdict.
   Assumes rgc_src gives reference, signal and the host gate timer. */
`timescale 1ns/1ps
`default_nettype none
module rgc_top_tb_top;
    logic        clk = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        arm_ext = 1'b0, tmr_go = 1'b0;
    logic [6:0]  arm_trig = 7'h0;
    logic [7:0]  fe_cfg;
    logic        route_shared, chan1_sig, chan2_sig, gate_open, irq;
    logic        ref_in, sig_in1, tmr_done;
    wire         sig_in2 = ~sig_in1;
    int          err_total = 0, checks_done = 0, cyc = 0;
    rgc_top u_rgc_top (.*);
    rgc_src u_rgc_src (.*);
    initial forever #20 clk = ~clk;
    // ********************
    // Tasks
    // ********************
    task automatic chk(input logic [31:0] seen, exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    // Data sampled at the edge closing the answer cycle
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask
    task automatic wirq(input int b);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < 1000 && v[b] !== 1'b1; i++)
            rd(rgc_pkg::OFS_IRQ_ST, v);
        chk(v[b], 1'b1, "irq status");
    endtask
    task automatic t_reset;
        logic [31:0] v;
        rd(rgc_pkg::OFS_CAL_LEN, v);
        chk(v, 32'h4, "cal len reset");
        rd(4'hf, v);
        chk(v, 32'h0, "unmapped read");
        chk(irq, 1'b0, "irq reset");
        $display("test reset done");
    endtask
    task automatic t_cfg;
        wr(rgc_pkg::OFS_CTRL, 32'ha520);
        @(negedge clk);
        chk(fe_cfg, 8'ha5, "fe_cfg");
        chk(chan2_sig, sig_in1, "shared channel two");
        wr(rgc_pkg::OFS_CTRL, 32'h10); // Stop needs an arm edge
        @(negedge clk);
        chk(chan2_sig, sig_in2, "separate channel two");
        $display("test cfg done");
    endtask
    task automatic t_meas;
        logic [31:0] s, r;
        wr(rgc_pkg::OFS_IRQ_MSK, 32'hf);
        wr(rgc_pkg::OFS_CMD, 32'h1);
        wirq(rgc_pkg::IRQ_OPEN);
        chk(gate_open, 1'b1, "gate open");
        tmr_go <= 1'b1;
        @(posedge clk);
        tmr_go <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 400 && !tmr_done; i++)
            @(posedge clk);
        wr(rgc_pkg::OFS_CMD, 32'h2);
        repeat (30) @(posedge clk);
        chk(gate_open, 1'b1, "stop waits arm");
        arm_ext <= 1'b1;
        repeat (2) @(posedge clk);
        arm_ext <= 1'b0;
        wirq(rgc_pkg::IRQ_DONE);
        chk(gate_open, 1'b0, "gate closed");
        rd(rgc_pkg::OFS_SIG_CNT, s);
        rd(rgc_pkg::OFS_REF_CNT, r);
        chk(s > 32'd8, 1'b1, "signal count");
        chk(r, s * 5, "ref count");
        $display("test meas done");
    endtask
    task automatic cal(input int c, input logic [31:0] w, output logic [31:0] v);
        wr(rgc_pkg::OFS_IRQ_ST, 32'hf);
        wr(rgc_pkg::OFS_CAL_LEN, w);
        wr(rgc_pkg::OFS_CMD, 32'h1 << c);
        wirq(rgc_pkg::IRQ_CAL);
        rd(rgc_pkg::OFS_STA_CNT + 4'(c - 2), v);
    endtask
    // Start then stop interpolator, two widths each
    task automatic t_cal;
        logic [31:0] a, b;
        for (int c = rgc_pkg::CMD_CAL_START; c <= rgc_pkg::CMD_CAL_STOP; c++)
        begin
            cal(c, 32'h2, a);
            cal(c, 32'h6, b);
            chk(b > a, 1'b1, "wider pulse counts more");
        end
        $display("test cal done");
    endtask
    // Every arming source in gated-start mode; signal chain clears on arm
    task automatic t_arm;
        logic [31:0] v;
        for (int s = 0; s < 8; s++)
        begin
            wr(rgc_pkg::OFS_IRQ_ST, 32'hf);
            wr(rgc_pkg::OFS_CTRL, 32'h8 | s);
            wr(rgc_pkg::OFS_CMD, 32'h1);
            rd(rgc_pkg::OFS_SIG_CNT, v);
            chk(v, 32'h0, "count cleared");
            @(posedge clk);
            if (s == 0)
                arm_ext <= 1'b1;
            else
                arm_trig[s - 1] <= 1'b1;
            repeat (2) @(posedge clk);
            arm_ext  <= 1'b0;
            arm_trig <= 7'h0;
            wirq(rgc_pkg::IRQ_ARMEVT);
        end
        wr(rgc_pkg::OFS_IRQ_MSK, 32'h0);
        wr(rgc_pkg::OFS_IRQ_MSK, 32'h8);
        @(negedge clk);
        chk(irq, 1'b1, "irq unmasked");
        wr(rgc_pkg::OFS_IRQ_ST, 32'h8);
        @(negedge clk);
        chk(irq, 1'b0, "irq cleared");
        $display("test arm done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard well above the expected run length
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_total++;
            conclude();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_cfg();
        t_meas();
        t_cal();
        t_arm();
        conclude();
    end
endmodule // rgc_top_tb_top
bind rgc_top rgc_assertions u_rgc_assertions (.*);
`default_nettype wire
